/* src/gfm_mapper.sv */
// gfm_mapper: multi-function pin logic, maps pin edges or a low pulse to device commands
// assumes a classic wishbone master on mclk; pin is asynchronous and is resynchronised here
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module gfm_mapper (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// multi-function pin
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	// status from the device
	input wire logic nvmBusy,
	input wire logic [3:0] dacBusy,
	input wire logic [3:0] winCmp,
	// commands to the device
	output logic deepSleep,
	output logic faultDumpPulse,
	output logic protectPulse,
	output logic clearPulse,
	output logic [3:0] loadPulse,
	output logic [3:0] ioutPowerDown,
	output logic [3:0] voutPowerDown,
	output logic [7:0] voutPulldownSel,
	output logic [3:0] funcGenRun,
	output logic [3:0] marginHigh,
	output logic [3:0] marginPulse,
	output logic devResetPulse,
	output logic nvmProgAllow,
	output logic regWriteAllow
);
	// registers
	logic [31:0] cfg_q;
	logic [31:0] cfg_d;
	logic [31:0] dat_q;
	logic ack_q;
	// pin synchroniser and edge history
	logic pinMeta_q;
	logic pinSync_q;
	logic pinPrev_q;
	logic booted_q;
	logic [1:0] fill_q;
	logic [7:0] lowCnt_q;
	// command state
	logic sleep_q;
	logic fdump_q;
	logic prot_q;
	logic clr_q;
	logic [3:0] load_q;
	logic [3:0] ipdn_q;
	logic [3:0] vpdn_q;
	logic [3:0] fgen_q;
	logic [3:0] mhi_q;
	logic [3:0] mpul_q;
	logic rst_q;
	logic nvlk_q;
	logic rglk_q;
	logic pout_q;
	logic poe_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// bus decode
	wire logic busReq = wb_cyc_i && wb_stb_i && !ack_q;
	wire logic wrCfg = busReq && wb_we_i && (wb_adr_i == gfm_pkg::CFG_OFS);
	wire logic wrSw = busReq && wb_we_i && (wb_adr_i == gfm_pkg::SWTRIG_OFS);
	wire logic [31:0] swWord = merge(32'h0000_0000, wb_dat_i, wb_sel_i);

	// configuration fields
	wire logic inEn = cfg_q[gfm_pkg::IEN_BIT];
	wire logic [3:0] inFunc = cfg_q[gfm_pkg::IFUNC_LSB +: 4];
	wire logic [3:0] chSel = cfg_q[gfm_pkg::CHSEL_LSB +: 4];
	wire logic [3:0] outFunc = cfg_q[gfm_pkg::OFUNC_LSB +: 4];
	wire logic outEn = cfg_q[gfm_pkg::OEN_BIT];
	wire logic rstNv = cfg_q[gfm_pkg::RSTNV_BIT];
	wire logic [3:0] syncCfg = cfg_q[gfm_pkg::SYNC_LSB +: 4];

	// pin events, only from the second synchroniser stage
	wire logic pinFall = booted_q && pinPrev_q && !pinSync_q;
	wire logic pinRise = booted_q && !pinPrev_q && pinSync_q;
	// boot sample waits until the real pin level has passed both stages, not their reset value
	wire logic initLow = fill_q[1] && !booted_q && !pinSync_q;
	wire logic initHigh = fill_q[1] && !booted_q && pinSync_q;
	wire logic lowEnd = pinRise && (lowCnt_q >= 8'(gfm_pkg::RST_PULSE_CYC));

	// pin drives a function only in input mode with a listed code
	wire logic isSel = inEn;
	function automatic logic hit(input logic sel, input logic [3:0] f, input gfm_pkg::gfm_func_t c);
		return sel && (f == c);
	endfunction
	wire logic mSleep = hit(isSel, inFunc, gfm_pkg::FN_SLEEP);
	wire logic mFdump = hit(isSel, inFunc, gfm_pkg::FN_FDUMP);
	wire logic mIpdn = hit(isSel, inFunc, gfm_pkg::FN_IPDN);
	wire logic mVpdn = hit(isSel, inFunc, gfm_pkg::FN_VPDN);
	wire logic mProt = hit(isSel, inFunc, gfm_pkg::FN_PROT);
	wire logic mClr = hit(isSel, inFunc, gfm_pkg::FN_CLR);
	wire logic mLoad = hit(isSel, inFunc, gfm_pkg::FN_LOAD);
	wire logic mFgen = hit(isSel, inFunc, gfm_pkg::FN_FGEN);
	wire logic mMarg = hit(isSel, inFunc, gfm_pkg::FN_MARG);
	wire logic mRst = hit(isSel, inFunc, gfm_pkg::FN_RST);
	wire logic mNvlk = hit(isSel, inFunc, gfm_pkg::FN_NVLK);
	wire logic mRglk = hit(isSel, inFunc, gfm_pkg::FN_RGLK);

	// pin "assert" (falling or low at boot) and "release" (rising or high at boot)
	wire logic pA = pinFall || initLow;
	wire logic pR = pinRise || initHigh;

	// software triggers, masked while the pin owns the function
	wire logic [3:0] swCh = swWord[gfm_pkg::SW_CH_LSB +: 4];
	wire logic swLvl = swWord[gfm_pkg::SW_LEVEL];
	function automatic logic swt(input logic wr, input logic [31:0] w, input int b, input logic mapped);
		return wr && w[b] && !mapped;
	endfunction
	wire logic sSleep = swt(wrSw, swWord, gfm_pkg::SW_SLEEP, mSleep);
	wire logic sFdump = swt(wrSw, swWord, gfm_pkg::SW_FDUMP, mFdump);
	wire logic sIpdn = swt(wrSw, swWord, gfm_pkg::SW_IPDN, mIpdn);
	wire logic sVpdn = swt(wrSw, swWord, gfm_pkg::SW_VPDN, mVpdn);
	wire logic sProt = swt(wrSw, swWord, gfm_pkg::SW_PROT, mProt);
	wire logic sClr = swt(wrSw, swWord, gfm_pkg::SW_CLR, mClr);
	wire logic sLoad = swt(wrSw, swWord, gfm_pkg::SW_LOAD, mLoad);
	wire logic sFgen = swt(wrSw, swWord, gfm_pkg::SW_FGEN, mFgen);
	wire logic sMarg = swt(wrSw, swWord, gfm_pkg::SW_MARG, mMarg);
	wire logic sRst = swt(wrSw, swWord, gfm_pkg::SW_RST, mRst);
	wire logic sNvlk = swt(wrSw, swWord, gfm_pkg::SW_NVLK, mNvlk);
	wire logic sRglk = swt(wrSw, swWord, gfm_pkg::SW_RGLK, mRglk);

	// register writes are blocked while locked, except the trigger word (unlock/reset)
	wire logic cfgWrOk = wrCfg && !rglk_q;
	// reset from a pin low pulse of at least RST_PULSE_CYC cycles; the software trigger fires at once with no pulse width
	wire logic rstFire = (mRst && lowEnd) || sRst;

	always_comb begin
		cfg_d = cfg_q;
		if (cfgWrOk) begin
			cfg_d = merge(cfg_q, wb_dat_i, wb_sel_i);
		end
		if (rstFire && !rstNv) begin
			cfg_d[gfm_pkg::IFUNC_LSB +: 4] = 4'h0;
			cfg_d[gfm_pkg::IEN_BIT] = 1'b0;
		end
	end

	// status selected onto the pin in output mode
	wire logic [3:0] busyIdx = outFunc - gfm_pkg::OUT_BUSY0;
	wire logic [3:0] cmpIdx = outFunc - gfm_pkg::OUT_CMP0;
	wire logic outStat = (outFunc == gfm_pkg::OUT_NVBUSY) ? nvmBusy :
		(outFunc >= gfm_pkg::OUT_BUSY0 && outFunc < gfm_pkg::OUT_CMP0) ? dacBusy[busyIdx[1:0]] :
		(outFunc >= gfm_pkg::OUT_CMP0 && outFunc < 4'hc) ? winCmp[cmpIdx[1:0]] : 1'b0;

	wire logic [31:0] rdMux = (wb_adr_i == gfm_pkg::CFG_OFS) ? cfg_q :
		(wb_adr_i == gfm_pkg::STATE_OFS) ? {8'h00, mhi_q, fgen_q, vpdn_q, ipdn_q, 4'h0, nvlk_q, rglk_q, 1'b0, sleep_q} :
		(wb_adr_i == gfm_pkg::INSTAT_OFS) ? {30'h0, booted_q, pinSync_q} : 32'h0000_0000;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_q <= gfm_pkg::CFG_RESET;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			cfg_q <= cfg_d;
			ack_q <= busReq;
			dat_q <= busReq ? rdMux : 32'h0000_0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			pinMeta_q <= 1'b1;
			pinSync_q <= 1'b1;
			pinPrev_q <= 1'b1;
			booted_q <= 1'b0;
			fill_q <= 2'h0;
			lowCnt_q <= 8'h00;
		end else begin
			pinMeta_q <= pinIn;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
			fill_q <= {fill_q[0], 1'b1};
			booted_q <= fill_q[1];
			lowCnt_q <= pinSync_q ? 8'h00 : ((lowCnt_q == 8'hff) ? lowCnt_q : lowCnt_q + 8'h01);
		end
	end

	// one-cycle command pulses and level states
	always_ff @(posedge mclk) begin
		if (reset) begin
			fdump_q <= 1'b0;
			prot_q <= 1'b0;
			clr_q <= 1'b0;
			load_q <= 4'h0;
			mpul_q <= 4'h0;
			rst_q <= 1'b0;
		end else begin
			fdump_q <= (mFdump && pinFall) || sFdump;
			prot_q <= (mProt && pinFall) || sProt;
			clr_q <= (mClr && pinFall) || sClr;
			load_q <= (mLoad && pinFall) ? (chSel & syncCfg) : (sLoad ? swCh & syncCfg : 4'h0);
			mpul_q <= (mMarg && (pA || pR)) ? chSel : (sMarg ? swCh : 4'h0);
			rst_q <= rstFire;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			sleep_q <= 1'b0;
			ipdn_q <= 4'h0;
			vpdn_q <= 4'h0;
			fgen_q <= 4'h0;
			mhi_q <= 4'h0;
			nvlk_q <= 1'b1;
			rglk_q <= 1'b0;
			pout_q <= 1'b0;
			poe_q <= 1'b0;
		end else begin
			if (mSleep && (pA || pR)) sleep_q <= pA;
			else if (sSleep) sleep_q <= swLvl;
			if (mIpdn && (pA || pR)) ipdn_q <= pA ? (ipdn_q | chSel) : (ipdn_q & ~chSel);
			else if (sIpdn) ipdn_q <= swLvl ? (ipdn_q | swCh) : (ipdn_q & ~swCh);
			if (mVpdn && (pA || pR)) vpdn_q <= pA ? (vpdn_q | chSel) : (vpdn_q & ~chSel);
			else if (sVpdn) vpdn_q <= swLvl ? (vpdn_q | swCh) : (vpdn_q & ~swCh);
			if (mFgen && (pA || pR)) fgen_q <= pR ? (fgen_q | chSel) : (fgen_q & ~chSel);
			else if (sFgen) fgen_q <= swLvl ? (fgen_q | swCh) : (fgen_q & ~swCh);
			if (mMarg && (pA || pR)) mhi_q <= pR ? (mhi_q | chSel) : (mhi_q & ~chSel);
			else if (sMarg) mhi_q <= swLvl ? (mhi_q | swCh) : (mhi_q & ~swCh);
			if (mNvlk && (pA || pR)) nvlk_q <= pR;
			else if (sNvlk) nvlk_q <= swLvl;
			if (mRglk && (pA || pR)) rglk_q <= pR;
			else if (sRglk) rglk_q <= swLvl;
			pout_q <= outStat;
			poe_q <= outEn && !inEn;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign pinOut = pout_q;
	assign pinOe = poe_q;
	assign deepSleep = sleep_q;
	assign faultDumpPulse = fdump_q;
	assign protectPulse = prot_q;
	assign clearPulse = clr_q;
	assign loadPulse = load_q;
	assign ioutPowerDown = ipdn_q;
	assign voutPowerDown = vpdn_q;
	assign voutPulldownSel = cfg_q[gfm_pkg::VPDN_LSB +: 8];
	assign funcGenRun = fgen_q;
	assign marginHigh = mhi_q;
	assign marginPulse = mpul_q;
	assign devResetPulse = rst_q;
	assign nvmProgAllow = !nvlk_q;
	assign regWriteAllow = !rglk_q;

	chk_sleep_fall: assert property (@(posedge mclk) disable iff (reset)
		(mSleep && pinFall) |=> deepSleep) else $error("sleep not entered on falling edge");
	chk_clear_rise: assert property (@(posedge mclk) disable iff (reset)
		(mClr && pinRise && !sClr) |=> !clearPulse) else $error("clear fired on rising edge");
	chk_load_chan: assert property (@(posedge mclk) disable iff (reset)
		(mLoad && pinFall) |=> (loadPulse == $past(chSel & syncCfg))) else $error("load hit wrong channels");
	chk_sw_masked: assert property (@(posedge mclk) disable iff (reset)
		(mClr && wrSw && swWord[gfm_pkg::SW_CLR] && !pinFall) |=> !clearPulse) else $error("masked sw clear fired");
	chk_reset_pulse: assert property (@(posedge mclk) disable iff (reset)
		(mRst && pinRise && lowCnt_q < 8'(gfm_pkg::RST_PULSE_CYC) && !sRst) |=> !devResetPulse)
		else $error("reset on short pulse");
	chk_fgen_rise: assert property (@(posedge mclk) disable iff (reset)
		(mFgen && pinRise) |=> ((funcGenRun & $past(chSel)) == $past(chSel))) else $error("fgen not started");
	chk_reg_lock: assert property (@(posedge mclk) disable iff (reset)
		(rglk_q && wrCfg && !rstFire) |=> $stable(cfg_q)) else $error("locked cfg written");
	chk_out_drive: assert property (@(posedge mclk) disable iff (reset)
		(outEn && !inEn) |=> pinOe) else $error("pin not driven");
	chk_in_release: assert property (@(posedge mclk) disable iff (reset)
		inEn |=> !pinOe) else $error("pin driven in input mode");
	chk_ipdn_fall: assert property (@(posedge mclk) disable iff (reset)
		(mIpdn && pinFall) |=> ((ioutPowerDown & $past(chSel)) == $past(chSel))) else $error("current_output not down");
endmodule

/* src/gfm_pkg.sv */
// gfm_pkg: register map, field layout, codes and timing for the pin function mapper
// assumes a 32-bit classic wishbone slave port and a 50 MHz clock
package gfm_pkg;
	// register byte offsets
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] SWTRIG_OFS = 8'h04;
	localparam logic [7:0] STATE_OFS = 8'h08;
	localparam logic [7:0] INSTAT_OFS = 8'h0c;
	// configuration field positions
	localparam int IEN_BIT = 0;
	localparam int IFUNC_LSB = 1;
	localparam int CHSEL_LSB = 5;
	localparam int OFUNC_LSB = 9;
	localparam int OEN_BIT = 13;
	localparam int RSTNV_BIT = 14;
	localparam int VPDN_LSB = 16;
	localparam int SYNC_LSB = 24;
	// software trigger bit positions
	localparam int SW_SLEEP = 0;
	localparam int SW_FDUMP = 1;
	localparam int SW_IPDN = 2;
	localparam int SW_VPDN = 3;
	localparam int SW_PROT = 4;
	localparam int SW_CLR = 5;
	localparam int SW_LOAD = 6;
	localparam int SW_FGEN = 7;
	localparam int SW_MARG = 8;
	localparam int SW_RST = 9;
	localparam int SW_NVLK = 10;
	localparam int SW_RGLK = 11;
	localparam int SW_LEVEL = 12;
	localparam int SW_CH_LSB = 16;
	// reset values
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// input function codes
	typedef enum logic [3:0] {
		FN_SLEEP = 4'h0, FN_FDUMP = 4'h2, FN_IPDN = 4'h3, FN_VPDN = 4'h4,
		FN_PROT = 4'h5, FN_CLR = 4'h7, FN_LOAD = 4'h8, FN_FGEN = 4'h9,
		FN_MARG = 4'ha, FN_RST = 4'hb, FN_NVLK = 4'hc, FN_RGLK = 4'hd
	} gfm_func_t;
	// output status codes
	localparam logic [3:0] OUT_NVBUSY = 4'h1;
	localparam logic [3:0] OUT_BUSY0 = 4'h4;
	localparam logic [3:0] OUT_CMP0 = 4'h8;
	// least low-pulse width for a reset, ns
	localparam int RST_PULSE_NS = 100;
	localparam int CLK_NS = 20;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* tb/gfm_mapper_bench.sv */
// gfm_mapper_bench: self-checking bench for the pin function mapper
// assumes gfm_pkg and gfm_mapper compiled first; pin driven by gfm_pin_model
`timescale 1ns/1ps
module gfm_mapper_bench;
	logic mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0, nvmBusy = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, dacBusy = 4'h0, winCmp = 4'h0, ldP, ipd, vpd, fgr, mh, mp, chs, syn, seenLd, seenMp;
	logic [31:0] datI = 32'h0, datO, q, pd;
	logic ack, pinIn, pinOut, pinOe, dsl, fdP, prP, clP, rstP, nvA, rgA;
	logic [7:0] vsel;
	logic [3:0] codes [4];
	int err_count = 0, comparisons = 0, cycles = 0, seed = 5, nFd, nPr, nCl, nRst;
	gfm_pin_model pin (.mclk(mclk), .pinLevel(pinIn));
	gfm_mapper dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .nvmBusy(nvmBusy), .dacBusy(dacBusy), .winCmp(winCmp), .deepSleep(dsl),
		.faultDumpPulse(fdP), .protectPulse(prP), .clearPulse(clP), .loadPulse(ldP), .ioutPowerDown(ipd),
		.voutPowerDown(vpd), .voutPulldownSel(vsel), .funcGenRun(fgr), .marginHigh(mh), .marginPulse(mp),
		.devResetPulse(rstP), .nvmProgAllow(nvA), .regWriteAllow(rgA));
	always #10 mclk = ~mclk;
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles > 20000) begin
			err_count++;
			stop_test();
		end
		nFd += fdP;
		nPr += prP;
		nCl += clP;
		nRst += rstP;
		seenLd |= ldP;
		seenMp |= mp;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		{cyc, stb, we, adr, datI, sel} <= {2'b11, w, a, d, 4'hf};
		do @(posedge mclk); while (ack !== 1'b1);
		q = datO;
		{cyc, stb} <= 2'b00;
		@(posedge mclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkCnt(input string n, input int e, input int g);
		comparisons++;
		if (g != e) begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic setCfg(input logic [3:0] code, input logic [31:0] extra);
		wb(1'b1, gfm_pkg::CFG_OFS, (32'(code) << gfm_pkg::IFUNC_LSB) | (32'(chs) << gfm_pkg::CHSEL_LSB) | extra | 32'h1);
		{nFd, nPr, nCl, nRst, seenLd, seenMp} = '0;
	endtask
	task automatic edgeTo(input logic v);
		pin.drive(v);
		repeat (6) @(posedge mclk);
	endtask
	initial begin
		codes = '{gfm_pkg::FN_FDUMP, gfm_pkg::FN_PROT, gfm_pkg::FN_CLR, 4'h1};
		{nFd, nPr, nCl, nRst, seenLd, seenMp} = '0;
		chs = 4'h0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		wb(1'b0, gfm_pkg::CFG_OFS, 32'h0);
		chk("cfg reset", gfm_pkg::CFG_RESET, q);
		edgeTo(1'b0);
		edgeTo(1'b1);
		chkCnt("idle pulses", 0, nFd + nPr + nCl + nRst);
		chk("idle locks", 3'b001, {dsl, nvA, rgA});
		$display("test defaults done");
		for (int i = 0; i < 4; i++) begin
			setCfg(codes[i], 32'h0);
			edgeTo(1'b0);
			edgeTo(1'b1);
			chkCnt("fault dump", i == 0, nFd);
			chkCnt("protect", i == 1, nPr);
			chkCnt("clear", i == 2, nCl);
		end
		$display("test global pulses done");
		setCfg(gfm_pkg::FN_SLEEP, 32'h0);
		chk("input mode oe", 1'b0, pinOe);
		edgeTo(1'b0);
		chk("sleep enter", 1'b1, dsl);
		edgeTo(1'b1);
		chk("sleep leave", 1'b0, dsl);
		chs = 4'($random(seed)) | 4'h1;
		pd = 32'($random(seed)) & 32'h00ff_0000;
		for (int k = 0; k < 2; k++) begin
			setCfg(k ? gfm_pkg::FN_VPDN : gfm_pkg::FN_IPDN, pd);
			edgeTo(1'b0);
			chk("powerdown", k ? {4'h0, chs} : {chs, 4'h0}, {ipd, vpd});
			chk("pulldown sel", pd[23:16], vsel);
			edgeTo(1'b1);
			chk("powerup", 8'h00, {ipd, vpd});
		end
		setCfg(gfm_pkg::FN_FGEN, 32'h0);
		edgeTo(1'b0);
		chk("fgen stop", 4'h0, fgr);
		edgeTo(1'b1);
		chk("fgen start", chs, fgr);
		setCfg(gfm_pkg::FN_MARG, 32'h0);
		edgeTo(1'b0);
		chk("margin low", 4'h0, mh & chs);
		edgeTo(1'b1);
		chk("margin high", chs, mh);
		chk("margin events", chs, seenMp);
		syn = 4'($random(seed)) | 4'h1;
		setCfg(gfm_pkg::FN_LOAD, 32'(syn) << gfm_pkg::SYNC_LSB);
		edgeTo(1'b0);
		edgeTo(1'b1);
		chk("load", chs & syn, seenLd);
		$display("test channel functions done");
		setCfg(gfm_pkg::FN_NVLK, 32'h0);
		edgeTo(1'b0);
		chk("store allow", 1'b1, nvA);
		edgeTo(1'b1);
		chk("store block", 1'b0, nvA);
		setCfg(gfm_pkg::FN_RGLK, 32'h0);
		edgeTo(1'b0);
		chk("reg allow", 1'b1, rgA);
		edgeTo(1'b1);
		chk("reg block", 1'b0, rgA);
		wb(1'b1, gfm_pkg::CFG_OFS, 32'h0);
		wb(1'b0, gfm_pkg::CFG_OFS, 32'h0);
		chk("locked cfg", {chs, gfm_pkg::FN_RGLK, 1'b1}, q[8:0]);
		edgeTo(1'b0);
		chk("reg unlock", 1'b1, rgA);
		setCfg(4'h6, 32'h0);
		edgeTo(1'b1);
		chk("unlisted code", 1'b1, rgA);
		$display("test locks done");
		setCfg(gfm_pkg::FN_CLR, 32'h0);
		wb(1'b1, gfm_pkg::SWTRIG_OFS, 32'h1 << gfm_pkg::SW_CLR);
		repeat (4) @(posedge mclk);
		chkCnt("sw clear mapped", 0, nCl);
		setCfg(gfm_pkg::FN_SLEEP, 32'h0);
		wb(1'b1, gfm_pkg::SWTRIG_OFS, 32'h1 << gfm_pkg::SW_CLR);
		repeat (4) @(posedge mclk);
		chkCnt("sw clear free", 1, nCl);
		for (int k = 0; k < 2; k++) begin
			setCfg(gfm_pkg::FN_RST, 32'(k) << gfm_pkg::RSTNV_BIT);
			pin.lowPulse(2);
			repeat (8) @(posedge mclk);
			chkCnt("short pulse", 0, nRst);
			pin.lowPulse(gfm_pkg::RST_PULSE_CYC);
			repeat (8) @(posedge mclk);
			chkCnt("reset pulse", 1, nRst);
			wb(1'b0, gfm_pkg::CFG_OFS, 32'h0);
			chk("reset mapping", k ? {gfm_pkg::FN_RST, 1'b1} : 5'h00, q[4:0]);
		end
		$display("test reset done");
		for (int k = 0; k < 9; k++) begin
			q = k == 8 ? gfm_pkg::OUT_NVBUSY : k < 4 ? gfm_pkg::OUT_BUSY0 + k : gfm_pkg::OUT_CMP0 + k - 4;
			wb(1'b1, gfm_pkg::CFG_OFS, (q << gfm_pkg::OFUNC_LSB) | (32'h1 << gfm_pkg::OEN_BIT));
			@(posedge mclk);
			{nvmBusy, dacBusy, winCmp} <= 9'($random(seed));
			repeat (4) @(posedge mclk);
			chk("status oe", 1'b1, pinOe);
			chk("status out", k == 8 ? nvmBusy : k < 4 ? dacBusy[k] : winCmp[k - 4], pinOut);
		end
		$display("test output mode done");
		stop_test();
	end
endmodule

/* tb/gfm_pin_model.sv */
// gfm_pin_model: external switch on the multi-function pin
// assumes the bench calls its tasks; the line idles high as with a pull-up
`timescale 1ns/1ps
module gfm_pin_model (
	// clock
	input wire logic mclk,
	// pin level
	output logic pinLevel
);
	initial pinLevel = 1'b1;
	task automatic drive(input logic v);
		@(posedge mclk);
		pinLevel <= v;
	endtask
	// low pulse of n cycles, then back to idle high
	task automatic lowPulse(input int n);
		drive(1'b0);
		repeat (n) @(posedge mclk);
		pinLevel <= 1'b1;
	endtask
endmodule
